// [pkg/dma_ctrl_pkg.sv]
// Package with register map, field positions and reset values of the DMA global control
package dma_ctrl_pkg;
    localparam int          ADDR_W          = 12;           // APB address width used
    localparam logic [11:0] OFF_GLOBAL_CTRL = 12'h000;      // Control register offset
    localparam logic [11:0] OFF_XFER_CMD    = 12'h004;      // Transfer request register
    localparam logic [11:0] OFF_XFER_STAT   = 12'h008;      // Transfer progress register
    localparam int          BIT_ENABLE      = 15;           // Global enable position
    localparam int          BIT_SUSPEND     = 12;           // Suspend position
    localparam int          BIT_ACTIVE      = 11;           // Activity flag position
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000; // Control reset value
    localparam logic [15:0] COUNT_RESET     = 16'h0000;     // Run length register reset value
    localparam int          COUNT_W         = 16;           // Word counter width
endpackage

// [hdl/dma_word_mover.sv]
// Word transfer engine that moves a counted run of words and can be paused
`timescale 1ns/10ps
module dma_word_mover
    import dma_ctrl_pkg::*;
#(
    parameter int CNT_W = dma_ctrl_pkg::COUNT_W     // Width of the word counter
)
(
    input  wire logic             pclk,            // Peripheral bus clock
    input  wire logic             presetn,         // Asynchronous reset, active low
    input  wire logic             enable,          // Module enabled
    input  wire logic             suspend,         // Pause all movement
    input  wire logic             start,           // Pulse: begin a run
    input  wire logic [CNT_W-1:0] length,          // Words in the run
    input  wire logic             bus_grant,       // Data bus granted for this cycle
    output logic                  bus_req,         // Request for the data bus
    output logic                  in_progress,     // A run is loaded
    output logic [CNT_W-1:0]      remaining        // Words still to move
);
    // Run state
    typedef enum logic [0:0] {
        MV_IDLE = 1'b0,     // Nothing to move
        MV_RUN  = 1'b1      // Run loaded
    } mover_state_t;

    mover_state_t     state_r;        // Current state
    logic [CNT_W-1:0] remaining_r;    // Words left, kept across pauses

    // Bus request only while running and not paused
    assign bus_req     = (state_r == MV_RUN) && enable && !suspend;
    assign in_progress = (state_r == MV_RUN);
    assign remaining   = remaining_r;

    // Run sequencing and word counting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r     <= MV_IDLE;
            remaining_r <= '0;
        end
        else if (!enable)
        begin
            // Disable abandons the run
            state_r     <= MV_IDLE;
            remaining_r <= '0;
        end
        else
        begin
            case (state_r)
                MV_IDLE:
                begin
                    if (start && (length != '0))
                    begin
                        state_r     <= MV_RUN;
                        remaining_r <= length;
                    end
                end
                MV_RUN:
                begin
                    // One word per granted cycle, none while paused
                    if (bus_req && bus_grant)
                    begin
                        remaining_r <= remaining_r - 1'b1;
                        if (remaining_r == {{(CNT_W-1){1'b0}}, 1'b1})
                        begin
                            state_r <= MV_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_r <= MV_IDLE;
                end
            endcase
        end
    end
endmodule

// [hdl/dma_global_control.sv]
// DMA global control: APB register slave, enable, suspend and activity flag
// Operation
// - Enable bit 15 turns whole module on.
// - Suspend bit 12 halts all transfers.
// - Activity flag bit 11 shows module active.
// - Unimplemented control bits read as zero.
`timescale 1ns/10ps
module dma_global_control
    import dma_ctrl_pkg::*;
#(
    parameter int CNT_W = dma_ctrl_pkg::COUNT_W     // Word counter width
)
(
    input  wire logic                     pclk,       // Peripheral bus clock
    input  wire logic                     presetn,    // Asynchronous reset, active low
    input  wire logic                     psel,       // APB select
    input  wire logic                     penable,    // APB access phase
    input  wire logic                     pwrite,     // APB write
    input  wire logic [dma_ctrl_pkg::ADDR_W-1:0] paddr, // APB byte address
    input  wire logic [31:0]              pwdata,     // APB write data
    input  wire logic [3:0]               pstrb,      // APB byte strobes
    output logic      [31:0]              prdata,     // APB read data
    output logic                          pready,     // APB ready
    output logic                          pslverr,    // APB error
    input  wire logic                     bus_grant,  // System data bus granted
    output logic                          bus_req,    // System data bus request
    output logic                          dma_enabled // Module enable level
);
    import dma_ctrl_pkg::*;

    // Register map, byte addresses in the package
    //   every register is one aligned 32-bit word
    //   control word: bit 15 enable, bit 12 suspend, bit 11 activity (read only)
    //   a control write without byte lane one is dropped whole
    //   run length: low CNT_W bits; a nonzero write while enabled, with no run loaded, starts a run
    //   words left: read only, counts down as words cross the data bus
    //   anything else: slave error, writes dropped, reads give zero
    // Hazard: disable drops a loaded run one cycle after enable_r falls, so words left then
    // reads zero rather than the point where the run stopped

    logic             enable_r;     // Global enable
    logic             suspend_r;    // Global suspend
    logic             start_r;      // One-cycle run start pulse
    logic [CNT_W-1:0] length_r;     // Length of the requested run
    logic             in_progress;  // Run loaded in the mover
    logic [CNT_W-1:0] remaining;    // Words still to move
    logic             active;       // Activity flag value
    logic             acc_phase;    // Access phase of a transfer
    logic             wr_en;        // Write takes effect this edge
    logic             rd_en;        // Read data taken this edge
    logic             rd_setup;     // Read setup cycle, read data loads
    logic             sel_ctrl;     // Address hits the control word
    logic             sel_cmd;      // Address hits the run length
    logic             sel_stat;     // Address hits the words left
    logic             addr_ok;      // Address maps to a register
    logic             ctrl_wr;      // Control write with its byte lane
    logic             cmd_wr;       // Run length write
    wire logic [31:0] ctrl_view;    // Control register as read
    logic [31:0]      rdata_nxt;    // Next read data

    // Zero-wait slave: every access completes in its first access cycle
    assign pready    = 1'b1;
    assign acc_phase = psel && penable;
    assign wr_en     = acc_phase && pwrite;
    assign rd_en     = acc_phase && !pwrite;
    assign rd_setup  = psel && !penable && !pwrite;

    // Address decode, one line per register
    assign sel_ctrl = (paddr == OFF_GLOBAL_CTRL);
    assign sel_cmd  = (paddr == OFF_XFER_CMD);
    assign sel_stat = (paddr == OFF_XFER_STAT);
    assign addr_ok  = sel_ctrl || sel_cmd || sel_stat;

    // Write qualifiers; control bits sit in byte lane one
    assign ctrl_wr = wr_en && sel_ctrl && pstrb[1];
    assign cmd_wr  = wr_en && sel_cmd;

    // Unmapped access answers with an error, nothing else changes
    assign pslverr = acc_phase && !addr_ok;

    // Enable level straight from its flip-flop
    assign dma_enabled = enable_r;

    // Activity flag: high while enabled, or while a run is still loaded
    // A suspended run keeps the flag up, so software cannot mistake a
    // paused transfer for a finished one
    // Low only once disabled with nothing left in the mover
    assign active = enable_r || in_progress;

    // Control register image, one slot per bit; unused slots keep reset zero
    // One branch per field keeps a new field a one-branch change
    for (genvar b = 0; b < 32; b++)
    begin : g_ctrl_bit
        if (b == BIT_ENABLE)
        begin : g_enable
            // Enable reads back as written
            assign ctrl_view[b] = enable_r;
        end
        else if (b == BIT_SUSPEND)
        begin : g_suspend
            // Suspend reads back as written
            assign ctrl_view[b] = suspend_r;
        end
        else if (b == BIT_ACTIVE)
        begin : g_active
            // Activity flag, read only
            assign ctrl_view[b] = active;
        end
        else
        begin : g_unused
            // Unimplemented, reads as zero
            assign ctrl_view[b] = CTRL_RESET[b];
        end
    end

    // Read data selection from the address decode
    // Registered one step later, in the setup cycle
    always_comb
    begin
        if (sel_ctrl)
        begin
            rdata_nxt = ctrl_view;
        end
        else if (sel_cmd)
        begin
            rdata_nxt = {{(32-CNT_W){1'b0}}, length_r};         // Run length
        end
        else if (sel_stat)
        begin
            rdata_nxt = {{(32-CNT_W){1'b0}}, remaining};        // Words left
        end
        else
        begin
            rdata_nxt = 32'h0000_0000;                          // Unmapped
        end
    end

    // Read data register, loaded in setup so it is valid in access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (rd_setup)
        begin
            // Load in setup, so the word stands for the whole access phase
            prdata <= rdata_nxt;
        end
        else if (rd_en)
        begin
            // Held through the access edge
            prdata <= prdata;
        end
    end

    // Enable and suspend bits, byte lane one carries them
    // Clearing enable also drops any loaded run in the mover
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Off, and not suspended, after reset
            enable_r  <= CTRL_RESET[BIT_ENABLE];
            suspend_r <= CTRL_RESET[BIT_SUSPEND];
        end
        else if (ctrl_wr)
        begin
            enable_r  <= pwdata[BIT_ENABLE];
            suspend_r <= pwdata[BIT_SUSPEND];
        end
    end

    // Run length register, kept for read back even while disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            length_r <= COUNT_RESET;
        end
        else if (cmd_wr)
        begin
            length_r <= pwdata[CNT_W-1:0];
        end
    end

    // Start pulse: a nonzero length write while enabled, with no run loaded, starts a run
    // A write while disabled only stores the length
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_r <= 1'b0;
        end
        else
        begin
            start_r <= cmd_wr && enable_r;
        end
    end

    // Word engine
    //   start pulse loads a run of length_r words
    //   one word per cycle with bus_req and bus_grant both high
    //   suspend drops bus_req but keeps the run and its count
    //   disable drops the run one cycle after enable_r falls; a read right after a
    // disable can therefore still find the run half done
    dma_word_mover #(
        .CNT_W       (CNT_W)
    ) u_mover (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (enable_r),
        .suspend     (suspend_r),
        .start       (start_r),
        .length      (length_r),
        .bus_grant   (bus_grant),
        .bus_req     (bus_req),
        .in_progress (in_progress),
        .remaining   (remaining)
    );
endmodule

// [bench/dma_ctrl_monitor.sv]
// Checker watching the DMA global control ports
`timescale 1ns/10ps
module dma_ctrl_monitor
    import dma_ctrl_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              bus_req,
    input wire logic              dma_enabled
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Control register access in the access phase
    wire ctl_acc = psel && penable && paddr == OFF_GLOBAL_CTRL;
    wire ctl_wr  = ctl_acc && pwrite && pstrb[1];
    wire ctl_rd  = ctl_acc && !pwrite;
    chk_enable_set:    assert property (ctl_wr && pwdata[15] |=> dma_enabled)
        else $error("enable did not follow a write of one");
    chk_enable_clear:  assert property (ctl_wr && !pwdata[15] |=> !dma_enabled)
        else $error("enable did not follow a write of zero");
    chk_req_needs_on:  assert property (bus_req |-> dma_enabled)
        else $error("bus requested while disabled");
    // Suspend write, then the data bus stays unrequested for the next two cycles
    sequence suspend_wr;
        ctl_wr && pwdata[BIT_SUSPEND];
    endsequence
    sequence bus_quiet;
        !bus_req [*2];
    endsequence
    chk_suspend_stops: assert property (suspend_wr |=> bus_quiet)
        else $error("bus requested while suspended");
    chk_zero_fields:   assert property (ctl_rd |-> (prdata & 32'hffff_67ff) == 32'h0)
        else $error("unimplemented control bits read nonzero");
    chk_busy_when_on:  assert property (ctl_rd && dma_enabled |-> prdata[BIT_ACTIVE])
        else $error("activity flag low while enabled");
endmodule

// [bench/dma_bus_partner.sv]
// Processor core model that shares the data bus with the DMA
`timescale 1ns/10ps
module dma_bus_partner
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic bus_req,
    input  wire logic cpu_busy,  // Core keeps the bus for itself
    output logic      bus_grant
);
    // Grant the bus only while the core leaves it free
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            bus_grant <= 1'b0;
        else
            bus_grant <= bus_req && !cpu_busy;
endmodule

// [bench/tb_top.sv]
// Testbench for the DMA global control block
`timescale 1ns/10ps
module tb_top;
    import dma_ctrl_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_busy = 1;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, bus_grant, bus_req, dma_enabled, e;
    int          n_mismatch = 0, num_checks = 0, i;
    int          n_words = 0;
    dma_global_control dma_global_control_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_grant(bus_grant), .bus_req(bus_req), .dma_enabled(dma_enabled));
    dma_bus_partner dma_bus_partner_inst (.pclk(pclk), .presetn(presetn),
        .bus_req(bus_req), .cpu_busy(cpu_busy), .bus_grant(bus_grant));
    // Words moved on the shared data bus: request and grant in one cycle
    always @(posedge pclk)
        if (bus_req && bus_grant)
            n_words <= n_words + 1;
    // Clock generator
    initial forever #25 pclk = ~pclk;
    // One APB transfer, idle cycle before the setup
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for pready; only the watchdog ends a wait that never sees it
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Compare seen against expected
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    // Verdict and end of run
    task automatic tally_and_finish;
        if (n_mismatch == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog against hangs
    initial
    begin
        #200000;
        n_mismatch++;
        tally_and_finish;
    end
    // Main sequence
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFF_GLOBAL_CTRL, 0);
        chk(q, 32'h0);
        apb(1, OFF_GLOBAL_CTRL, 32'hffff_ffff);
        apb(0, OFF_GLOBAL_CTRL, 0);
        chk(q, 32'h0000_9800);
        apb(1, OFF_GLOBAL_CTRL, 32'h0);
        @(posedge pclk);               // Master stays off the bus right after disable
        pstrb <= 4'hd;
        apb(1, OFF_GLOBAL_CTRL, 32'h8000);
        pstrb <= 4'hf;
        apb(0, OFF_GLOBAL_CTRL, 0);
        chk(q, 32'h0);
        apb(0, 12'hffc, 0);
        chk({q[31:1], e}, 32'h1);
        apb(1, OFF_GLOBAL_CTRL, 32'h8000);
        apb(1, OFF_XFER_CMD, 32'h3);
        apb(1, OFF_GLOBAL_CTRL, 32'h9000);
        cpu_busy <= 1'b0;
        repeat (6) apb(0, OFF_XFER_STAT, 0);
        chk(q, 32'h3);
        chk(n_words, 32'h0);
        apb(0, OFF_GLOBAL_CTRL, 0);
        chk(q, 32'h0000_9800);
        apb(1, OFF_GLOBAL_CTRL, 32'h8000);
        for (i = 0; i < 20 && q !== 32'h0; i++)
            apb(0, OFF_XFER_STAT, 0);
        chk(q, 32'h0);
        chk(n_words, 32'h3);
        apb(0, OFF_GLOBAL_CTRL, 0);
        chk(q, 32'h0000_8800);
        apb(1, OFF_GLOBAL_CTRL, 32'h0);
        @(posedge pclk);               // Master stays off the bus right after disable
        apb(0, OFF_GLOBAL_CTRL, 0);
        chk(q, 32'h0);
        tally_and_finish;
    end
endmodule
bind dma_global_control dma_ctrl_monitor dma_ctrl_monitor_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .bus_req(bus_req),
    .dma_enabled(dma_enabled));
